/* File: rtl/cdi_core.sv */
// Execution block for the interrupt-disable and unsigned divide instructions.
// Assumes an AXI4-Lite master on aclk and asynchronous interrupt request pins.
//
// Overview of operation
// (RULE1) Interrupt-disable instruction clears bit 0 of the system mode register.
// (RULE2) Requests still set pending bits while disabled; none is serviced then.
// (RULE3) Interrupt-disable leaves every condition flag as it was.
// (RULE4) Interrupt-disable is opcode 8F and takes 4 cycles.
// (RULE5) Software should disable interrupts before editing mask or pending state.
// (RULE6) Divide treats a 16-bit dividend and 8-bit divisor as unsigned.
// (RULE7) Quotient goes to the lower half, remainder to the upper half.
// (RULE8) Even register of the pair takes remainder, following odd takes quotient.
// (RULE9) Overflow set on zero divisor or quotient above eight bits.
// (RULE10) Carry set only on overflow with quotient 256 to 511.
// (RULE11) Zero set when divisor or quotient is zero.
// (RULE12) Sign copies quotient bit 7; decimal-adjust and half-carry stay.
// (RULE13) Divide is three bytes; 94 register, 95 indirect, 96 immediate source.
// (RULE14) Divide takes 10 cycles on zero divisor, 26 otherwise.
//
// Design decisions made here: the AXI4-Lite slave port and the register offsets.
module cdi_core #(
  parameter int unsigned ADDR_W = 12,
  parameter int unsigned IRQ_W = 8
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address
  input wire logic [ADDR_W-1:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  // AXI4-Lite write data
  input wire logic [cdi_pkg::DATA_W-1:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  // AXI4-Lite write response
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  // AXI4-Lite read address
  input wire logic [ADDR_W-1:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  // AXI4-Lite read data
  output logic [cdi_pkg::DATA_W-1:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready,
  // Interrupt requests and service
  input wire logic [IRQ_W-1:0] irq_req,
  output logic global_int_en,
  output logic int_take,
  output logic [2:0] int_vector
);
  import cdi_pkg::*;

  if (ADDR_W < REG_AW || IRQ_W < 1 || IRQ_W > 8)
  begin : g_chk
    $error("cdi_core: ADDR_W must be >= 8 and IRQ_W in 1..8");
  end

  // ==========================================================
  // Declarations
  logic aw_full_q, aw_full_d, w_full_q, w_full_d;
  logic [ADDR_W-1:0] aw_addr_q, aw_addr_d;
  logic [DATA_W-1:0] w_data_q, w_data_d;
  logic [3:0] w_strb_q, w_strb_d;
  logic awready_q, awready_d, wready_q, wready_d;
  logic bvalid_q, bvalid_d, arready_q, arready_d, rvalid_q, rvalid_d;
  logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
  logic [DATA_W-1:0] rdata_q, rdata_d;
  logic do_write;
  logic [7:0] wa;
  logic sw_instr, sw_flags, sw_smr, sw_pclr, sw_mask, sw_wreg;

  cdi_exec_t ex_q, ex_d;
  logic [4:0] cnt_q, cnt_d;
  cdi_instr_t ins_q, ins_d;
  cdi_div_in_t din_q, din_d;
  cdi_div_out_t dout;
  logic [7:0] flags_q, flags_d, smr_q, smr_d;
  logic bad_q, bad_d, take_q, take_d;
  logic [2:0] vec_q, vec_d;
  logic [7:0] wreg_q [16];
  logic [7:0] wreg_d [16];
  cdi_instr_t new_ins;
  logic [7:0] src_val;

  logic [7:0] pend_q, pend_d, mask_q, mask_d;
  logic [IRQ_W-1:0] irq_rise;
  logic [7:0] irq_rise8;

  // ==========================================================
  // Helpers
  function automatic logic cdi_mapped(input logic [ADDR_W-1:0] a);
    logic [7:0] lo;
    lo = a[7:0];
    cdi_mapped = ((a >> REG_AW) == '0) && (lo[1:0] == 2'b00) &&
      ((lo <= OFF_IRQ_VEC) || ((lo >= OFF_WREG_BASE) && (lo <= OFF_WREG_LAST)));
  endfunction

  // Register-pair halves: even index upper, following odd index lower
  function automatic logic [3:0] cdi_pair(input logic [7:0] b, input logic odd);
    cdi_pair = {b[3:1], odd}; // RULE8
  endfunction

  function automatic logic [2:0] cdi_lowest(input logic [7:0] v);
    cdi_lowest = 3'h0;
    for (int i = 7; i >= 0; i--)
    begin
      if (v[i])
      begin
        cdi_lowest = 3'(i);
      end
    end
  endfunction

  // ==========================================================
  // Submodules
  cdi_sync #(.W(IRQ_W)) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .pin(irq_req),
    .level(),
    .rise(irq_rise)
  );

  cdi_divu u_div (
    .din(din_q),
    .dout(dout)
  );

  assign irq_rise8 = 8'(irq_rise);

  // ==========================================================
  // AXI4-Lite slave: address and data held independently, write once both are in
  always_comb
  begin
    aw_full_d = aw_full_q;
    aw_addr_d = aw_addr_q;
    w_full_d = w_full_q;
    w_data_d = w_data_q;
    w_strb_d = w_strb_q;
    bvalid_d = bvalid_q && !s_bready;
    bresp_d = bresp_q;
    rvalid_d = rvalid_q && !s_rready;
    rresp_d = rresp_q;
    rdata_d = rdata_q;
    do_write = aw_full_q && w_full_q && !bvalid_q;
    wa = aw_addr_q[7:0];
    sw_instr = 1'b0;
    sw_flags = 1'b0;
    sw_smr = 1'b0;
    sw_pclr = 1'b0;
    sw_mask = 1'b0;
    sw_wreg = 1'b0;
    if (s_awvalid && awready_q)
    begin
      aw_full_d = 1'b1;
      aw_addr_d = s_awaddr;
    end
    if (s_wvalid && wready_q)
    begin
      w_full_d = 1'b1;
      w_data_d = s_wdata;
      w_strb_d = s_wstrb;
    end
    if (do_write)
    begin
      aw_full_d = 1'b0;
      w_full_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = cdi_mapped(aw_addr_q) ? RESP_OKAY : RESP_SLVERR;
      if (cdi_mapped(aw_addr_q))
      begin
        // Opcode, source and destination bytes must arrive together
        sw_instr = (wa == OFF_INSTR) && (w_strb_q[2:0] == 3'b111);
        sw_flags = (wa == OFF_FLAGS) && w_strb_q[0];
        sw_smr = (wa == OFF_SYSMODE) && w_strb_q[0];
        sw_pclr = (wa == OFF_IRQ_PEND) && w_strb_q[0];
        sw_mask = (wa == OFF_IRQ_MASK) && w_strb_q[0];
        sw_wreg = (wa >= OFF_WREG_BASE) && w_strb_q[0];
      end
    end
    awready_d = !aw_full_d;
    wready_d = !w_full_d;
    if (s_arvalid && arready_q)
    begin
      rvalid_d = 1'b1;
      rdata_d = 32'h0000_0000;
      rresp_d = cdi_mapped(s_araddr) ? RESP_OKAY : RESP_SLVERR;
      if (cdi_mapped(s_araddr))
      begin
        case (s_araddr[7:0])
          OFF_INSTR: rdata_d[23:0] = ins_q;
          OFF_STATUS:
          begin
            rdata_d[STS_BUSY] = (ex_q != EX_IDLE);
            rdata_d[STS_BADOPC] = bad_q;
          end
          OFF_FLAGS: rdata_d[7:0] = flags_q;
          OFF_SYSMODE: rdata_d[7:0] = smr_q;
          OFF_IRQ_PEND: rdata_d[7:0] = pend_q;
          OFF_IRQ_MASK: rdata_d[7:0] = mask_q;
          OFF_IRQ_VEC: rdata_d[2:0] = vec_q;
          default: rdata_d[7:0] = wreg_q[s_araddr[5:2]];
        endcase
      end
    end
    arready_d = !rvalid_d;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_full_q <= 1'b0;
      aw_addr_q <= '0;
      w_full_q <= 1'b0;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
      awready_q <= 1'b0;
      wready_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
      rresp_q <= RESP_OKAY;
      rdata_q <= 32'h0000_0000;
    end
    else
    begin
      aw_full_q <= aw_full_d;
      aw_addr_q <= aw_addr_d;
      w_full_q <= w_full_d;
      w_data_q <= w_data_d;
      w_strb_q <= w_strb_d;
      awready_q <= awready_d;
      wready_q <= wready_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      arready_q <= arready_d;
      rvalid_q <= rvalid_d;
      rresp_q <= rresp_d;
      rdata_q <= rdata_d;
    end
  end

  // ==========================================================
  // Instruction execution and interrupt acceptance
  always_comb
  begin
    ex_d = ex_q;
    cnt_d = cnt_q;
    ins_d = ins_q;
    din_d = din_q;
    flags_d = flags_q;
    smr_d = smr_q;
    bad_d = bad_q;
    take_d = 1'b0;
    vec_d = vec_q;
    wreg_d = wreg_q;
    new_ins = w_data_q[23:0];
    // Operand source by addressing mode
    case (new_ins.opcode)
      OPC_DIV_REG: src_val = wreg_q[new_ins.src[3:0]]; // RULE13
      OPC_DIV_IND: src_val = wreg_q[wreg_q[new_ins.src[3:0]][3:0]]; // RULE13
      default: src_val = new_ins.src; // RULE13
    endcase
    case (ex_q)
      EX_IDLE:
      begin
        // Flags, system mode and working registers are only writable while no instruction runs
        if (sw_flags)
        begin
          flags_d = w_data_q[7:0];
        end
        if (sw_smr)
        begin
          smr_d = w_data_q[7:0];
        end
        if (sw_wreg)
        begin
          wreg_d[wa[5:2]] = w_data_q[7:0];
        end
        if (sw_instr)
        begin
          ins_d = new_ins;
          bad_d = 1'b0;
          case (new_ins.opcode)
            OPC_IOFF:
            begin
              ex_d = EX_IOFF; // RULE4
              cnt_d = CYC_IOFF - 5'h01; // RULE4
            end
            OPC_DIV_REG, OPC_DIV_IND, OPC_DIV_IMM:
            begin
              ex_d = EX_DIV; // RULE13
              din_d.dividend = {wreg_q[cdi_pair(new_ins.dst, 1'b0)], wreg_q[cdi_pair(new_ins.dst, 1'b1)]}; // RULE8
              din_d.divisor = src_val;
              cnt_d = (src_val == 8'h00) ? CYC_DIV_ZERO - 5'h01 : CYC_DIV - 5'h01; // RULE14
            end
            default: bad_d = 1'b1;
          endcase
        end
        else if (smr_q[GIE_BIT] && ((pend_q & mask_q) != 8'h00))
        begin
          // Servicing drops the global enable so one request vectors once
          take_d = 1'b1; // RULE2
          vec_d = cdi_lowest(pend_q & mask_q);
          smr_d[GIE_BIT] = 1'b0;
        end
      end
      EX_IOFF:
      begin
        if (cnt_q == 5'h00)
        begin
          smr_d[GIE_BIT] = 1'b0; // RULE1 RULE3
          ex_d = EX_IDLE;
        end
        else
        begin
          cnt_d = cnt_q - 5'h01;
        end
      end
      EX_DIV:
      begin
        if (cnt_q == 5'h00)
        begin
          flags_d[FLG_C] = dout.c; // RULE10
          flags_d[FLG_Z] = dout.z; // RULE11
          flags_d[FLG_S] = dout.s; // RULE12
          flags_d[FLG_V] = dout.v; // RULE9
          // A zero divisor leaves the pair untouched; overflowed results are written anyway
          if (din_q.divisor != 8'h00)
          begin
            wreg_d[cdi_pair(ins_q.dst, 1'b0)] = dout.rem; // RULE7 RULE8
            wreg_d[cdi_pair(ins_q.dst, 1'b1)] = dout.quot; // RULE7 RULE8
          end
          ex_d = EX_IDLE;
        end
        else
        begin
          cnt_d = cnt_q - 5'h01;
        end
      end
      default: ex_d = EX_IDLE;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ex_q <= EX_IDLE;
      cnt_q <= 5'h00;
      ins_q <= '0;
      din_q <= '0;
      flags_q <= FLAGS_RST;
      smr_q <= SYSMODE_RST;
      bad_q <= 1'b0;
      take_q <= 1'b0;
      vec_q <= 3'h0;
      for (int i = 0; i < 16; i++)
      begin
        wreg_q[i] <= WREG_RST;
      end
    end
    else
    begin
      ex_q <= ex_d;
      cnt_q <= cnt_d;
      ins_q <= ins_d;
      din_q <= din_d;
      flags_q <= flags_d;
      smr_q <= smr_d;
      bad_q <= bad_d;
      take_q <= take_d;
      vec_q <= vec_d;
      wreg_q <= wreg_d;
    end
  end

  // ==========================================================
  // Pending and mask: a new request beats a clear in the same cycle
  always_comb
  begin
    pend_d = pend_q;
    mask_d = mask_q;
    if (sw_pclr)
    begin
      pend_d = pend_q & ~w_data_q[7:0];
    end
    pend_d = pend_d | irq_rise8; // RULE2
    if (sw_mask)
    begin
      mask_d = w_data_q[7:0];
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pend_q <= 8'h00;
      mask_q <= MASK_RST;
    end
    else
    begin
      pend_q <= pend_d;
      mask_q <= mask_d;
    end
  end

  // ==========================================================
  // Outputs
  assign s_awready = awready_q;
  assign s_wready = wready_q;
  assign s_bvalid = bvalid_q;
  assign s_bresp = bresp_q;
  assign s_arready = arready_q;
  assign s_rvalid = rvalid_q;
  assign s_rresp = rresp_q;
  assign s_rdata = rdata_q;
  assign global_int_en = smr_q[GIE_BIT];
  assign int_take = take_q;
  assign int_vector = vec_q;

endmodule

/* File: rtl/cdi_divu.sv */
// Combinational unsigned 16-by-8 divide with flag generation.
// Assumes the caller holds the operands stable until it commits the result.
module cdi_divu (
  // Operands
  input cdi_pkg::cdi_div_in_t din,
  // Result and flags
  output cdi_pkg::cdi_div_out_t dout
);
  import cdi_pkg::*;

  logic [15:0] q_full;
  logic [15:0] r_full;
  logic dz;

  // ==========================================================
  // Divide; the full quotient is kept so overflow can be judged
  always_comb
  begin
    dz = (din.divisor == 8'h00);
    q_full = 16'h0000;
    r_full = 16'h0000;
    if (!dz)
    begin
      q_full = din.dividend / {8'h00, din.divisor}; // RULE6
      r_full = din.dividend % {8'h00, din.divisor}; // RULE6
    end
    dout.quot = q_full[7:0]; // RULE7
    dout.rem = r_full[7:0]; // RULE7
    dout.v = dz || (q_full[15:8] != 8'h00); // RULE9
    dout.c = !dz && (q_full[15:9] == 7'h00) && q_full[8]; // RULE10
    dout.z = dz || (q_full == 16'h0000); // RULE11
    dout.s = q_full[7]; // RULE12
  end

endmodule

/* File: rtl/cdi_pkg.sv */
// Shared constants and types for the divide / interrupt-disable execution block.
// Assumes a single core clock; all offsets are byte addresses on a 32-bit AXI4-Lite bus.
package cdi_pkg;

  // ==========================================================
  // Bus geometry
  localparam int unsigned REG_AW = 8;
  localparam int unsigned DATA_W = 32;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ==========================================================
  // Register offsets
  localparam logic [7:0] OFF_INSTR = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_FLAGS = 8'h08;
  localparam logic [7:0] OFF_SYSMODE = 8'h0C;
  localparam logic [7:0] OFF_IRQ_PEND = 8'h10;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h14;
  localparam logic [7:0] OFF_IRQ_VEC = 8'h18;
  localparam logic [7:0] OFF_WREG_BASE = 8'h40;
  localparam logic [7:0] OFF_WREG_LAST = 8'h7C;

  // ==========================================================
  // Field positions
  localparam int unsigned FLG_C = 7;
  localparam int unsigned FLG_Z = 6;
  localparam int unsigned FLG_S = 5;
  localparam int unsigned FLG_V = 4;
  localparam int unsigned FLG_D = 3;
  localparam int unsigned FLG_H = 2;
  localparam int unsigned GIE_BIT = 0;
  localparam int unsigned STS_BUSY = 0;
  localparam int unsigned STS_BADOPC = 1;

  // ==========================================================
  // Reset values
  localparam logic [7:0] FLAGS_RST = 8'h00;
  localparam logic [7:0] SYSMODE_RST = 8'h00;
  localparam logic [7:0] MASK_RST = 8'h00;
  localparam logic [7:0] WREG_RST = 8'h00;

  // ==========================================================
  // Opcodes and cycle counts
  localparam logic [7:0] OPC_IOFF = 8'h8F;
  localparam logic [7:0] OPC_DIV_REG = 8'h94;
  localparam logic [7:0] OPC_DIV_IND = 8'h95;
  localparam logic [7:0] OPC_DIV_IMM = 8'h96;
  localparam logic [4:0] CYC_IOFF = 5'h04;
  localparam logic [4:0] CYC_DIV_ZERO = 5'h0A;
  localparam logic [4:0] CYC_DIV = 5'h1A;

  // ==========================================================
  // Types
  typedef enum logic [1:0] {
    EX_IDLE = 2'b00,
    EX_IOFF = 2'b01,
    EX_DIV = 2'b10
  } cdi_exec_t;

  typedef struct packed {
    logic [7:0] dst;
    logic [7:0] src;
    logic [7:0] opcode;
  } cdi_instr_t;

  typedef struct packed {
    logic [15:0] dividend;
    logic [7:0] divisor;
  } cdi_div_in_t;

  typedef struct packed {
    logic [7:0] quot;
    logic [7:0] rem;
    logic c;
    logic z;
    logic s;
    logic v;
  } cdi_div_out_t;

endpackage

/* File: rtl/cdi_sync.sv */
// Three-stage input synchroniser with agreement filter and rising-edge pulse.
// Assumes inputs are asynchronous to aclk; the first stage feeds only the second.
module cdi_sync #(
  parameter int unsigned W = 8
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Pins in, filtered level and rise out
  input wire logic [W-1:0] pin,
  output logic [W-1:0] level,
  output logic [W-1:0] rise
);

  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] st3_q;
  logic [W-1:0] lvl_q;
  logic [W-1:0] lvl_d;

  if (W < 1)
  begin : g_chk
    $error("cdi_sync: W must be at least 1");
  end

  // ==========================================================
  // Filter: a change counts once stages two and three agree
  always_comb
  begin
    lvl_d = lvl_q;
    for (int i = 0; i < W; i++)
    begin
      if (s2_q[i] == st3_q[i])
      begin
        lvl_d[i] = s2_q[i];
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s1_q <= '0;
      s2_q <= '0;
      st3_q <= '0;
      lvl_q <= '0;
    end
    else
    begin
      s1_q <= pin;
      s2_q <= s1_q;
      st3_q <= s2_q;
      lvl_q <= lvl_d;
    end
  end

  assign level = lvl_q;
  assign rise = lvl_d & ~lvl_q;

endmodule

/* File: test/cdi_core_assertions.sv */
// Port-level checks for the divide and interrupt-disable block.
// Assumes it is bound into cdi_core and sees nothing but its ports.
module cdi_core_assertions #(
  parameter int unsigned ADDR_W = 12
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Write channels
  input wire logic [ADDR_W-1:0] s_awaddr,
  input wire logic s_awvalid,
  input wire logic s_awready,
  input wire logic [cdi_pkg::DATA_W-1:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  input wire logic s_wready,
  input wire logic [1:0] s_bresp,
  input wire logic s_bvalid,
  input wire logic s_bready,
  // Read channels
  input wire logic [ADDR_W-1:0] s_araddr,
  input wire logic s_arvalid,
  input wire logic s_arready,
  input wire logic [cdi_pkg::DATA_W-1:0] s_rdata,
  input wire logic [1:0] s_rresp,
  input wire logic s_rvalid,
  input wire logic s_rready,
  // Interrupt service
  input wire logic global_int_en,
  input wire logic int_take,
  input wire logic [2:0] int_vector
);
  import cdi_pkg::*;
  logic [ADDR_W-1:0] aw_q;
  logic [ADDR_W-1:0] ar_q;
  logic [7:0] wop_q;
  logic [2:0] wst_q;
  // ==========================================================
  // Address and data arrive apart, so each is held until the answer
  always_ff @(posedge aclk)
  begin
    if (s_awvalid && s_awready)
      aw_q <= s_awaddr;
    if (s_arvalid && s_arready)
      ar_q <= s_araddr;
    if (s_wvalid && s_wready)
      wop_q <= s_wdata[7:0];
    if (s_wvalid && s_wready)
      wst_q <= s_wstrb[2:0];
  end
  function automatic logic mapped(logic [ADDR_W-1:0] a);
    return a[ADDR_W-1:8] == '0 && a[1:0] == 2'h0 &&
      (a[7:0] <= OFF_IRQ_VEC || (a[7:0] >= OFF_WREG_BASE && a[7:0] <= OFF_WREG_LAST));
  endfunction
  // ==========================================================
  // Assertions
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  bresp_map_a: assert property ($rose(s_bvalid) |-> s_bresp == (mapped(aw_q) ? RESP_OKAY : RESP_SLVERR))
    else $error("write response does not match address");
  rresp_map_a: assert property ($rose(s_rvalid) |-> s_rresp == (mapped(ar_q) ? RESP_OKAY : RESP_SLVERR))
    else $error("read response does not match address");
  bad_rdata_a: assert property (s_rvalid && s_rresp == RESP_SLVERR |-> s_rdata == '0)
    else $error("refused read returned data");
  b_hold_a: assert property (s_bvalid && !s_bready |=> s_bvalid && $stable(s_bresp))
    else $error("write response dropped early");
  r_hold_a: assert property (s_rvalid && !s_rready |=> s_rvalid && $stable(s_rdata))
    else $error("read data dropped early");
  ar_block_a: assert property (s_rvalid |-> !s_arready)
    else $error("read address taken during response");
  ioff_clear_a: assert property ($rose(s_bvalid) && aw_q == OFF_INSTR && wst_q == 3'h7
    && wop_q == OPC_IOFF && global_int_en |-> global_int_en [*4] ##1 !global_int_en)
    else $error("interrupt disable not done in four cycles");
  take_en_a: assert property (int_take |-> $past(global_int_en))
    else $error("interrupt taken while disabled");
  take_pulse_a: assert property (int_take |=> !int_take && !global_int_en)
    else $error("interrupt take not a single pulse");
  vec_hold_a: assert property (!int_take |-> $stable(int_vector))
    else $error("vector moved without a take");
  cover property (int_take);
  cover property ($rose(s_bvalid) && s_bresp == RESP_SLVERR);
  cover property ($fell(global_int_en) && !int_take);
endmodule

bind cdi_core cdi_core_assertions #(.ADDR_W(ADDR_W)) chk_u (
  .aclk(aclk), .aresetn(aresetn), .s_awaddr(s_awaddr), .s_awvalid(s_awvalid), .s_awready(s_awready),
  .s_wdata(s_wdata), .s_wstrb(s_wstrb), .s_wvalid(s_wvalid), .s_wready(s_wready), .s_bresp(s_bresp),
  .s_bvalid(s_bvalid), .s_bready(s_bready), .s_araddr(s_araddr), .s_arvalid(s_arvalid),
  .s_arready(s_arready), .s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid), .s_rready(s_rready),
  .global_int_en(global_int_en), .int_take(int_take), .int_vector(int_vector)
);

/* File: test/testbench.sv */
// Self-checking bench for the divide and interrupt-disable block.
// Assumes cdi_core with its checker bound; the bench is the bus master.
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  import cdi_pkg::*;
  logic aclk = 0, aresetn = 0, s_awvalid = 0, s_wvalid = 0, s_bready = 0, s_arvalid = 0, s_rready = 0;
  logic [11:0] s_awaddr = '0, s_araddr = '0;
  logic [31:0] s_wdata = '0, s_rdata, rd_data;
  logic [3:0] s_wstrb = '0;
  logic [7:0] irq_req = '0, f, dv;
  logic [15:0] n;
  logic [1:0] s_bresp, s_rresp, last_resp, rd_resp;
  logic [2:0] int_vector;
  logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid, global_int_en, int_take;
  int num_errors = 0, total_checks = 0, take_cnt = 0, q, d, s, md;
  logic [15:0] cn [8] = '{16'h1003, 16'h1003, 16'h1003, 16'h01FF, 16'h0200, 16'hFFFF, 16'h0000, 16'h0100};
  logic [7:0] cd [8] = '{8'h40, 8'h80, 8'h20, 8'h01, 8'h01, 8'h00, 8'h07, 8'h01};
  logic [11:0] bad [3] = '{12'h020, 12'h80C, 12'h00E};
  always #2 aclk = ~aclk;
  always @(posedge aclk)
    if (int_take === 1'b1)
      take_cnt <= take_cnt + 1;
  cdi_core #(.ADDR_W(12), .IRQ_W(8)) dut_u (
    .aclk(aclk), .aresetn(aresetn), .s_awaddr(s_awaddr), .s_awvalid(s_awvalid), .s_awready(s_awready),
    .s_wdata(s_wdata), .s_wstrb(s_wstrb), .s_wvalid(s_wvalid), .s_wready(s_wready), .s_bresp(s_bresp),
    .s_bvalid(s_bvalid), .s_bready(s_bready), .s_araddr(s_araddr), .s_arvalid(s_arvalid),
    .s_arready(s_arready), .s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid),
    .s_rready(s_rready), .irq_req(irq_req), .global_int_en(global_int_en), .int_take(int_take),
    .int_vector(int_vector)
  );
  // ==========================================================
  // Reporting
  task automatic stop_test();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic tmo(int k);
    if (k > 60)
    begin
      num_errors++;
      $display("[ERR] wait expected done seen timeout");
      stop_test();
    end
  endtask
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    total_checks++;
    if (g !== e)
    begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // ==========================================================
  // Bus master; instruction writes never stall so execution timing stays fixed
  task automatic w(logic [11:0] a, logic [31:0] dt);
    int k;
    @(posedge aclk);
    s_awaddr <= a;
    s_awvalid <= 1;
    s_wdata <= dt;
    s_wstrb <= 4'hF;
    s_wvalid <= 1;
    s_bready <= a == OFF_INSTR || $urandom_range(1);
    for (k = 0; !(s_bvalid === 1'b1 && s_bready); k++)
    begin
      @(posedge aclk);
      tmo(k);
      if (s_awready === 1'b1)
        s_awvalid <= 0;
      if (s_wready === 1'b1)
        s_wvalid <= 0;
      if (s_bvalid === 1'b1 && !s_bready)
        s_bready <= 1;
    end
    last_resp = s_bresp;
    s_bready <= 0;
  endtask
  task automatic rd(logic [11:0] a);
    int k;
    @(posedge aclk);
    s_araddr <= a;
    s_arvalid <= 1;
    s_rready <= $urandom_range(1);
    for (k = 0; !(s_rvalid === 1'b1 && s_rready); k++)
    begin
      @(posedge aclk);
      tmo(k);
      if (s_arready === 1'b1)
        s_arvalid <= 0;
      if (s_rvalid === 1'b1 && !s_rready)
        s_rready <= 1;
    end
    rd_data = s_rdata;
    rd_resp = s_rresp;
    s_rready <= 0;
  endtask
  task automatic rchk(logic [11:0] a, logic [31:0] e, string nm);
    rd(a);
    chk(nm, e, rd_data);
  endtask
  task automatic idle_wait();
    for (int k = 0; k < 62; k++)
    begin
      rd(OFF_STATUS);
      if (rd_data[STS_BUSY] === 1'b0)
        return;
      tmo(k);
    end
  endtask
  function automatic logic [11:0] wa(int i);
    return 12'(OFF_WREG_BASE) + 12'(4 * i);
  endfunction
  function automatic logic [7:0] exp_flags(logic [15:0] nn, logic [7:0] dd, logic [7:0] ff);
    int qq;
    qq = (dd == 0) ? 0 : nn / dd;
    exp_flags = ff;
    exp_flags[FLG_C] = qq >= 256 && qq <= 511;
    exp_flags[FLG_Z] = dd == 0 || qq == 0;
    exp_flags[FLG_S] = qq[7];
    exp_flags[FLG_V] = dd == 0 || qq > 255;
  endfunction
  // ==========================================================
  // Main sequence
  initial
  begin
    void'($urandom(32'hbea6));
    repeat (8) @(posedge aclk);
    aresetn <= 1;
    rchk(OFF_FLAGS, 32'(FLAGS_RST), "flags_rst");
    rchk(OFF_IRQ_MASK, 32'(MASK_RST), "mask_rst");
    rchk(OFF_IRQ_PEND, 0, "pend_rst");
    foreach (bad[i])
    begin
      w(bad[i], 1);
      chk("bresp", 32'(RESP_SLVERR), 32'(last_resp));
      rd(bad[i]);
      chk("rresp", 32'(RESP_SLVERR), 32'(rd_resp));
    end
    rchk(OFF_SYSMODE, 32'(SYSMODE_RST), "sysmode_rst");
    $display("test reset done");
    w(OFF_SYSMODE, 1);
    f = 8'($urandom) & 8'hFC;
    w(OFF_FLAGS, 32'(f));
    w(OFF_INSTR, 32'(OPC_IOFF));
    rchk(OFF_STATUS, 1, "busy_ioff");
    idle_wait();
    rchk(OFF_SYSMODE, 0, "sysmode_ioff");
    rchk(OFF_FLAGS, 32'(f), "flags_ioff");
    $display("test disable done");
    for (int i = 0; i < 24; i++)
    begin
      n = (i < 8) ? cn[i] : 16'($urandom);
      dv = (i < 8) ? cd[i] : ($urandom_range(4) == 0 ? 8'h00 : 8'($urandom));
      md = i % 3;
      d = $urandom_range(7) * 2;
      s = (d + 2) % 16;
      f = 8'($urandom) & 8'hFC;
      w(wa(d), 32'(n[15:8]));
      w(wa(d + 1), 32'(n[7:0]));
      w(wa(s), md == 1 ? 32'((d + 4) % 16) : 32'(dv));
      w(wa((d + 4) % 16), 32'(dv));
      w(OFF_FLAGS, 32'(f));
      w(OFF_INSTR, {8'h00, 8'(d), md == 2 ? dv : 8'(s), OPC_DIV_REG + 8'(md)});
      repeat (18) @(posedge aclk);
      rchk(OFF_STATUS, 32'(dv != 0), "busy_div");
      idle_wait();
      q = (dv == 0) ? 0 : n / dv;
      rchk(wa(d), dv == 0 ? 32'(n[15:8]) : 32'(8'(n % dv)), "upper");
      rchk(wa(d + 1), dv == 0 ? 32'(n[7:0]) : 32'(q[7:0]), "lower");
      rchk(OFF_FLAGS, 32'(exp_flags(n, dv, f)), "flags_div");
    end
    $display("test divide done");
    w(OFF_INSTR, 32'h0000_00AA);
    rchk(OFF_STATUS, 32'h0000_0002, "bad_opc");
    rchk(OFF_INSTR, 32'h0000_00AA, "instr_rd");
    w(OFF_IRQ_MASK, 8'h28);
    irq_req <= 8'h28;
    repeat (8) @(posedge aclk);
    irq_req <= 8'h00;
    repeat (8) @(posedge aclk);
    rchk(OFF_IRQ_PEND, 8'h28, "pend_set");
    chk("takes_off", 0, 32'(take_cnt));
    w(OFF_SYSMODE, 1);
    for (int k = 0; k < 20 && take_cnt == 0; k++)
      @(posedge aclk);
    chk("takes_on", 1, 32'(take_cnt));
    chk("vector", 3, 32'(int_vector));
    rchk(OFF_SYSMODE, 0, "sysmode_take");
    chk("int_en_take", 0, 32'(global_int_en));
    rchk(OFF_IRQ_VEC, 3, "vec_reg");
    w(OFF_IRQ_PEND, 8'h08);
    rchk(OFF_IRQ_PEND, 8'h20, "pend_clr");
    $display("test interrupt done");
    stop_test();
  end
endmodule
